// *** hdl/mie_pkg.sv ***
// constants, encodings and carrier types of the move/indirect execution unit
package mie_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET  = 12'h000;
  localparam logic [11:0] ACC_OFFSET   = 12'h004;
  localparam logic [11:0] STAT_OFFSET  = 12'h008;
  localparam logic [11:0] BANK_OFFSET  = 12'h00c;
  localparam logic [11:0] PAGE_OFFSET  = 12'h010;
  localparam logic [11:0] PTR0_OFFSET  = 12'h014;
  localparam logic [11:0] PTR1_OFFSET  = 12'h018;
  localparam logic [11:0] MADDR_OFFSET = 12'h01c;
  localparam logic [11:0] MDATA_OFFSET = 12'h020;

  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_ZERO_BIT = 0;

  localparam logic        RUN_RST   = 1'b1;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic        ZERO_RST  = 1'b0;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [6:0]  PAGE_RST  = 7'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [10:0] MADDR_RST = 11'h000;

  // ----------------------------------------------------------------
  // data memory and indirect window
  // ----------------------------------------------------------------
  localparam int          DMEM_AW     = 11;
  localparam int          DMEM_DEPTH  = 2048;
  localparam logic [6:0]  WIN0_FILE   = 7'h00;
  localparam logic [6:0]  WIN1_FILE   = 7'h01;

  // ----------------------------------------------------------------
  // instruction encodings (14-bit word): pattern under mask
  // ----------------------------------------------------------------
  localparam logic [13:0] LIT_ACC_MASK = 14'h3f00;
  localparam logic [13:0] LIT_ACC_PAT  = 14'h3000;
  localparam logic [13:0] PAGE_MASK    = 14'h3f80;
  localparam logic [13:0] PAGE_PAT     = 14'h3180;
  localparam logic [13:0] STF_MASK     = 14'h3f80;
  localparam logic [13:0] STF_PAT      = 14'h0080;
  localparam logic [13:0] COPY_MASK    = 14'h3f00;
  localparam logic [13:0] COPY_PAT     = 14'h0800;
  localparam logic [13:0] BANK_MASK    = 14'h3fe0;
  localparam logic [13:0] BANK_PAT     = 14'h0020;
  localparam logic [13:0] IND_MASK     = 14'h3ff0;
  localparam logic [13:0] IND_PAT      = 14'h0010;
  localparam logic [13:0] REL_MASK     = 14'h3f00;
  localparam logic [13:0] REL_PAT      = 14'h3f00;

  localparam int IND_STORE_BIT = 3;
  localparam int IND_SEL_BIT   = 2;
  localparam int REL_STORE_BIT = 7;
  localparam int REL_SEL_BIT   = 6;
  localparam int COPY_DEST_BIT = 7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRE_INC  = 2'b00,
    PRE_DEC  = 2'b01,
    POST_INC = 2'b10,
    POST_DEC = 2'b11
  } mie_ptr_mode_type;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_LIT_ACC = 3'b001,
    OP_PAGE    = 3'b010,
    OP_STF     = 3'b011,
    OP_COPY    = 3'b100,
    OP_BANK    = 3'b101,
    OP_IND     = 3'b110,
    OP_REL     = 3'b111
  } mie_op_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mie_apb_req_type;

  typedef struct packed {
    logic               en;
    logic [DMEM_AW-1:0] addr;
    logic [7:0]         data;
  } mie_mem_wr_type;

  typedef struct packed {
    logic               run;
    logic [7:0]         acc;
    logic               zero;
    logic [3:0]         bank;
    logic [6:0]         page;
    logic [15:0]        ptr0;
    logic [15:0]        ptr1;
    logic [DMEM_AW-1:0] maddr;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } mie_state_type;

endpackage

// *** hdl/mie_exec.sv ***
// move/indirect execution unit with data memory and apb register slave
//
// Behaviour
// [RULE_01] indirect load copies pointed byte into accumulator, zero flag follows it
// [RULE_02] mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec around access
// [RULE_03] relative form: address is pointer plus offset -32..31, pointer kept
// [RULE_04] indirect window has no storage; access goes to pointer's address
// [RULE_05] pointers are 16 bits and wrap modulo 65536
// [RULE_06] automatic pointer update never changes a status flag
// [RULE_07] indirect store writes accumulator through pointer, flags untouched
// [RULE_08] load-bank puts literal 0..15 into bank select, status kept
// [RULE_09] load-page puts 7-bit literal into program counter high latch
// [RULE_10] load-literal puts 8-bit value into accumulator, one cycle, no flags
// [RULE_11] store-to-file copies accumulator to 7-bit file address, one cycle
// [RULE_12] every handled instruction completes in one cycle, one word
// [RULE_13] copy-file: dest 0 to accumulator, 1 back to file, zero updated
`timescale 1ns/1ps
`default_nettype none

module mie_exec (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     instr_valid,
  input  wire logic [13:0]              instr_word,
  output logic                          instr_ready,
  output logic [7:0]                    acc_out,
  output logic                          zero_out,
  output logic [3:0]                    bank_select,
  output logic [6:0]                    program_counter_high_latch,
  input  wire mie_pkg::mie_apb_req_type apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  mie_pkg::mie_state_type  state_reg;
  mie_pkg::mie_state_type  state_next;
  mie_pkg::mie_mem_wr_type mem_wr;
  logic [7:0]              dmem_mem [0:mie_pkg::DMEM_DEPTH-1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  mie_pkg::mie_op_type       op;
  mie_pkg::mie_ptr_mode_type pointer_mode_field;
  logic                      fire;
  logic                      ptr_sel;
  logic [15:0]               ptr_val;
  logic [15:0]               ptr_new;
  logic [15:0]               eff_addr;
  logic [15:0]               rel_offset;
  logic                      is_store;
  logic [6:0]                file_addr;
  logic [mie_pkg::DMEM_AW-1:0] file_loc;
  logic [7:0]                rd_val;
  logic                      apb_setup;
  logic                      apb_wr;
  logic                      apb_hit;

  always_comb begin
    if ((instr_word & mie_pkg::REL_MASK) == mie_pkg::REL_PAT) begin
      op = mie_pkg::OP_REL;
    end else if ((instr_word & mie_pkg::PAGE_MASK) == mie_pkg::PAGE_PAT) begin
      op = mie_pkg::OP_PAGE;
    end else if ((instr_word & mie_pkg::LIT_ACC_MASK) == mie_pkg::LIT_ACC_PAT) begin
      op = mie_pkg::OP_LIT_ACC;
    end else if ((instr_word & mie_pkg::STF_MASK) == mie_pkg::STF_PAT) begin
      op = mie_pkg::OP_STF;
    end else if ((instr_word & mie_pkg::COPY_MASK) == mie_pkg::COPY_PAT) begin
      op = mie_pkg::OP_COPY;
    end else if ((instr_word & mie_pkg::BANK_MASK) == mie_pkg::BANK_PAT) begin
      op = mie_pkg::OP_BANK;
    end else if ((instr_word & mie_pkg::IND_MASK) == mie_pkg::IND_PAT) begin
      op = mie_pkg::OP_IND;
    end else begin
      op = mie_pkg::OP_NONE;
    end
  end

  assign fire               = instr_valid & state_reg.run;
  assign pointer_mode_field = mie_pkg::mie_ptr_mode_type'(instr_word[1:0]);
  assign ptr_sel            = (op == mie_pkg::OP_REL) ? instr_word[mie_pkg::REL_SEL_BIT]
                                                      : instr_word[mie_pkg::IND_SEL_BIT];
  assign is_store           = (op == mie_pkg::OP_REL) ? instr_word[mie_pkg::REL_STORE_BIT]
                                                      : instr_word[mie_pkg::IND_STORE_BIT];
  assign ptr_val            = ptr_sel ? state_reg.ptr1 : state_reg.ptr0;
  assign rel_offset         = {{10{instr_word[5]}}, instr_word[5:0]};
  assign file_addr          = instr_word[6:0];

  // ----------------------------------------------------------------
  // address generation
  // ----------------------------------------------------------------
  // 16-bit adders wrap by construction, no carry kept
  always_comb begin
    eff_addr = ptr_val;
    ptr_new  = ptr_val;
    if (op == mie_pkg::OP_REL) begin
      eff_addr = ptr_val + rel_offset;                                  // [RULE_03] [RULE_05]
    end else begin
      unique case (pointer_mode_field)
        mie_pkg::PRE_INC: begin
          eff_addr = ptr_val + 16'h0001;                                // [RULE_02] [RULE_05]
          ptr_new  = ptr_val + 16'h0001;
        end
        mie_pkg::PRE_DEC: begin
          eff_addr = ptr_val - 16'h0001;                                // [RULE_02] [RULE_05]
          ptr_new  = ptr_val - 16'h0001;
        end
        mie_pkg::POST_INC: begin
          ptr_new  = ptr_val + 16'h0001;                                // [RULE_02] [RULE_05]
        end
        mie_pkg::POST_DEC: begin
          ptr_new  = ptr_val - 16'h0001;                                // [RULE_02] [RULE_05]
        end
      endcase
    end
  end

  // the window files are aliases; the memory behind them is never used
  always_comb begin
    if (file_addr == mie_pkg::WIN0_FILE) begin
      file_loc = state_reg.ptr0[mie_pkg::DMEM_AW-1:0];                  // [RULE_04]
    end else if (file_addr == mie_pkg::WIN1_FILE) begin
      file_loc = state_reg.ptr1[mie_pkg::DMEM_AW-1:0];                  // [RULE_04]
    end else begin
      file_loc = {state_reg.bank, file_addr};
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite & state_reg.pready;

  always_comb begin
    unique case (apb_req.paddr)
      mie_pkg::CTRL_OFFSET, mie_pkg::ACC_OFFSET, mie_pkg::STAT_OFFSET,
      mie_pkg::BANK_OFFSET, mie_pkg::PAGE_OFFSET, mie_pkg::PTR0_OFFSET,
      mie_pkg::PTR1_OFFSET, mie_pkg::MADDR_OFFSET, mie_pkg::MDATA_OFFSET: apb_hit = 1'b1;
      default: apb_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next         = state_reg;
    mem_wr             = '0;
    rd_val             = 8'h00;
    state_next.pready  = apb_setup;
    state_next.pslverr = apb_setup & ~apb_hit;
    state_next.prdata  = 32'h0000_0000;

    // read data captured at setup, so it shows the pre-edge contents
    if (apb_setup) begin
      unique case (apb_req.paddr)
        mie_pkg::CTRL_OFFSET:  state_next.prdata[mie_pkg::CTRL_RUN_BIT] = state_reg.run;
        mie_pkg::ACC_OFFSET:   state_next.prdata[7:0] = state_reg.acc;
        mie_pkg::STAT_OFFSET:  state_next.prdata[mie_pkg::STAT_ZERO_BIT] = state_reg.zero;
        mie_pkg::BANK_OFFSET:  state_next.prdata[3:0] = state_reg.bank;
        mie_pkg::PAGE_OFFSET:  state_next.prdata[6:0] = state_reg.page;
        mie_pkg::PTR0_OFFSET:  state_next.prdata[15:0] = state_reg.ptr0;
        mie_pkg::PTR1_OFFSET:  state_next.prdata[15:0] = state_reg.ptr1;
        mie_pkg::MADDR_OFFSET: state_next.prdata[mie_pkg::DMEM_AW-1:0] = state_reg.maddr;
        mie_pkg::MDATA_OFFSET: state_next.prdata[7:0] = dmem_mem[state_reg.maddr];
        default:               state_next.prdata = 32'h0000_0000;
      endcase
    end

    // software writes go first so that an instruction in the same cycle wins
    if (apb_wr) begin
      unique case (apb_req.paddr)
        mie_pkg::CTRL_OFFSET:  state_next.run   = apb_req.pwdata[mie_pkg::CTRL_RUN_BIT];
        mie_pkg::ACC_OFFSET:   state_next.acc   = apb_req.pwdata[7:0];
        mie_pkg::STAT_OFFSET:  state_next.zero  = apb_req.pwdata[mie_pkg::STAT_ZERO_BIT];
        mie_pkg::BANK_OFFSET:  state_next.bank  = apb_req.pwdata[3:0];
        mie_pkg::PAGE_OFFSET:  state_next.page  = apb_req.pwdata[6:0];
        mie_pkg::PTR0_OFFSET:  state_next.ptr0  = apb_req.pwdata[15:0];
        mie_pkg::PTR1_OFFSET:  state_next.ptr1  = apb_req.pwdata[15:0];
        mie_pkg::MADDR_OFFSET: state_next.maddr = apb_req.pwdata[mie_pkg::DMEM_AW-1:0];
        mie_pkg::MDATA_OFFSET: begin
          mem_wr.en   = 1'b1;
          mem_wr.addr = state_reg.maddr;
          mem_wr.data = apb_req.pwdata[7:0];
        end
        default: state_next.run = state_reg.run;
      endcase
    end

    // each accepted word is executed entirely at this one edge
    if (fire) begin                                                     // [RULE_12]
      unique case (op)
        mie_pkg::OP_NONE: begin
          state_next.acc = state_next.acc;
        end
        mie_pkg::OP_LIT_ACC: begin
          state_next.acc = instr_word[7:0];                             // [RULE_10]
        end
        mie_pkg::OP_PAGE: begin
          state_next.page = instr_word[6:0];                            // [RULE_09]
        end
        mie_pkg::OP_BANK: begin
          // the literal field is five bits wide but only 0..15 is legal
          state_next.bank = instr_word[3:0];                            // [RULE_08]
        end
        mie_pkg::OP_STF: begin
          mem_wr.en   = 1'b1;                                           // [RULE_11]
          mem_wr.addr = file_loc;
          mem_wr.data = state_reg.acc;
        end
        mie_pkg::OP_COPY: begin
          rd_val          = dmem_mem[file_loc];
          state_next.zero = (rd_val == 8'h00);                          // [RULE_13]
          if (instr_word[mie_pkg::COPY_DEST_BIT]) begin
            mem_wr.en   = 1'b1;                                         // [RULE_13]
            mem_wr.addr = file_loc;
            mem_wr.data = rd_val;
          end else begin
            state_next.acc = rd_val;                                    // [RULE_13]
          end
        end
        mie_pkg::OP_IND, mie_pkg::OP_REL: begin
          if (is_store) begin
            mem_wr.en   = 1'b1;                                         // [RULE_07]
            mem_wr.addr = eff_addr[mie_pkg::DMEM_AW-1:0];
            mem_wr.data = state_reg.acc;
          end else begin
            rd_val          = dmem_mem[eff_addr[mie_pkg::DMEM_AW-1:0]];
            state_next.acc  = rd_val;                                   // [RULE_01]
            state_next.zero = (rd_val == 8'h00);                        // [RULE_01]
          end
          // pointer update touches only the pointer, never the flag
          if (ptr_sel) begin
            state_next.ptr1 = ptr_new;                                  // [RULE_06]
          end else begin
            state_next.ptr0 = ptr_new;                                  // [RULE_06]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.run     <= mie_pkg::RUN_RST;
      state_reg.acc     <= mie_pkg::ACC_RST;
      state_reg.zero    <= mie_pkg::ZERO_RST;
      state_reg.bank    <= mie_pkg::BANK_RST;
      state_reg.page    <= mie_pkg::PAGE_RST;
      state_reg.ptr0    <= mie_pkg::PTR_RST;
      state_reg.ptr1    <= mie_pkg::PTR_RST;
      state_reg.maddr   <= mie_pkg::MADDR_RST;
      state_reg.pready  <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata  <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // data memory holds no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (mem_wr.en) begin
      dmem_mem[mem_wr.addr] <= mem_wr.data;
    end
  end

  assign instr_ready                = state_reg.run;
  assign acc_out                    = state_reg.acc;
  assign zero_out                   = state_reg.zero;
  assign bank_select                = state_reg.bank;
  assign program_counter_high_latch = state_reg.page;
  assign prdata                     = state_reg.prdata;
  assign pready                     = state_reg.pready;
  assign pslverr                    = state_reg.pslverr;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic ev_ld;
  logic ev_st;
  logic ev_ind;
  assign ev_ind = fire & ((op == mie_pkg::OP_IND) | (op == mie_pkg::OP_REL));
  assign ev_ld  = ev_ind & ~is_store & ~apb_wr;
  assign ev_st  = ev_ind & is_store & ~apb_wr;

  property p_load_zero;
    ev_ld |=> (acc_out == $past(rd_val)) && (zero_out == (acc_out == 8'h00));
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("indirect load result wrong"); // [RULE_01]

  property p_pre_addr;
    ev_ind && (op == mie_pkg::OP_IND) && !pointer_mode_field[1] |-> eff_addr == ptr_new;
  endproperty
  a_pre_addr: assert property (p_pre_addr) else $error("pre mode address not updated pointer"); // [RULE_02]

  property p_post_addr;
    ev_ind && (op == mie_pkg::OP_IND) && pointer_mode_field[1] |-> eff_addr == ptr_val && ptr_new != ptr_val;
  endproperty
  a_post_addr: assert property (p_post_addr) else $error("post mode address not old pointer"); // [RULE_02]

  property p_rel_keep;
    ev_ind && (op == mie_pkg::OP_REL) && !apb_wr |=> (($past(ptr_sel) ? state_reg.ptr1 : state_reg.ptr0)
                                                     == $past(ptr_val));
  endproperty
  a_rel_keep: assert property (p_rel_keep) else $error("relative form moved pointer"); // [RULE_03]

  property p_window;
    fire && (op == mie_pkg::OP_STF) && (file_addr <= mie_pkg::WIN1_FILE) |-> mem_wr.en && mem_wr.addr ==
      (file_addr[0] ? state_reg.ptr1[mie_pkg::DMEM_AW-1:0] : state_reg.ptr0[mie_pkg::DMEM_AW-1:0]);
  endproperty
  a_window: assert property (p_window) else $error("window access not redirected"); // [RULE_04]

  property p_wrap;
    ev_ind && (op == mie_pkg::OP_IND) && !apb_wr && ptr_val == 16'hffff && !pointer_mode_field[0]
      |=> ($past(ptr_sel) ? state_reg.ptr1 : state_reg.ptr0) == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [RULE_05]

  property p_store_flags;
    ev_st |-> mem_wr.en && mem_wr.data == acc_out ##1 $stable(zero_out) && $stable(acc_out);
  endproperty
  a_store_flags: assert property (p_store_flags) else $error("indirect store disturbed state"); // [RULE_06] [RULE_07]

  property p_bank;
    fire && (op == mie_pkg::OP_BANK) && !apb_wr |=> bank_select == $past(instr_word[3:0]) && $stable(zero_out);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not loaded"); // [RULE_08]

  property p_page;
    fire && (op == mie_pkg::OP_PAGE) && !apb_wr
      |=> program_counter_high_latch == $past(instr_word[6:0]) && $stable(zero_out);
  endproperty
  a_page: assert property (p_page) else $error("page latch not loaded"); // [RULE_09]

  property p_lit;
    fire && (op == mie_pkg::OP_LIT_ACC) && !apb_wr |=> acc_out == $past(instr_word[7:0]) && $stable(zero_out);
  endproperty
  a_lit: assert property (p_lit) else $error("literal not loaded"); // [RULE_10]

  property p_stf;
    fire && (op == mie_pkg::OP_STF) && file_addr > mie_pkg::WIN1_FILE
      |-> mem_wr.en && mem_wr.addr == {bank_select, file_addr} && mem_wr.data == acc_out;
  endproperty
  a_stf: assert property (p_stf) else $error("store to file wrong"); // [RULE_11]

  property p_one_cycle;
    instr_ready && !apb_wr |=> instr_ready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("unit stalled"); // [RULE_12]

  property p_copy;
    fire && (op == mie_pkg::OP_COPY) && instr_word[mie_pkg::COPY_DEST_BIT] && !apb_wr
      |-> mem_wr.en && mem_wr.addr == file_loc ##1 $stable(acc_out) && zero_out == ($past(rd_val) == 8'h00);
  endproperty
  a_copy: assert property (p_copy) else $error("copy to file wrong"); // [RULE_13]

  c_load: cover property (ev_ld ##1 zero_out);
  c_store: cover property (ev_st);
  c_wrap: cover property (ev_ind && ptr_val == 16'hffff);
  c_apb: cover property (apb_wr ##1 fire);

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the move/indirect execution unit
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                     core_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     instr_valid = 1'b0;
  logic [13:0]              instr_word = 14'h0000;
  mie_pkg::mie_apb_req_type apb_req = '0;
  logic                     instr_ready;
  logic                     zero_out;
  logic                     pready;
  logic                     pslverr;
  logic [7:0]               acc_out;
  logic [3:0]               bank_select;
  logic [6:0]               program_counter_high_latch;
  logic [31:0]              prdata;
  logic [31:0]              rdat;
  logic [15:0]              ea;
  logic [7:0]               ev;
  int                       mismatches = 0;
  int                       total_checks = 0;

  always #5 core_clk = ~core_clk;

  mie_exec u_dut (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .acc_out(acc_out), .zero_out(zero_out), .bank_select(bank_select),
    .program_counter_high_latch(program_counter_high_latch), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    chk("pslverr", {31'h0, a > 12'h020}, {31'h0, pslverr});
    apb_req <= '0;
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  task automatic mwr(input logic [10:0] a, input logic [7:0] v);
    apb(1'b1, mie_pkg::MADDR_OFFSET, {21'h0, a});
    apb(1'b1, mie_pkg::MDATA_OFFSET, {24'h0, v});
  endtask

  task automatic mrd(input logic [10:0] a, input logic [7:0] v);
    apb(1'b1, mie_pkg::MADDR_OFFSET, {21'h0, a});
    rd("mem", mie_pkg::MDATA_OFFSET, {24'h0, v});
  endtask

  // outputs are looked at 1 ns after the executing edge has landed
  task automatic exec(input logic [13:0] w);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd("ctrl", mie_pkg::CTRL_OFFSET, 32'h1);
    rd("ptr1", mie_pkg::PTR1_OFFSET, 32'h0);
    exec(14'h30a5);
    chk("acc", 32'ha5, {24'h0, acc_out});
    chk("zero", 32'h0, {31'h0, zero_out});
    $display("test reset and literal done");
    mwr(11'h004, 8'h44);
    mwr(11'h005, 8'h00);
    mwr(11'h006, 8'h66);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, mie_pkg::PTR0_OFFSET, 32'h5);
      ea = m[0] ? 16'h0004 : 16'h0006;
      ev = m[1] ? 8'h00 : (m[0] ? 8'h44 : 8'h66);
      exec(14'h0010 | 14'(m));
      chk("acc", {24'h0, ev}, {24'h0, acc_out});
      chk("zero", {31'h0, ev == 8'h00}, {31'h0, zero_out});
      rd("ptr0", mie_pkg::PTR0_OFFSET, {16'h0, ea});
    end
    $display("test pointer modes done");
    exec(14'h303c);
    chk("zero", 32'h1, {31'h0, zero_out});
    apb(1'b1, mie_pkg::PTR1_OFFSET, 32'h0);
    exec(14'h001d);
    rd("ptr1", mie_pkg::PTR1_OFFSET, 32'hffff);
    chk("zero", 32'h1, {31'h0, zero_out});
    mrd(11'h7ff, 8'h3c);
    exec(14'h001e);
    rd("ptr1", mie_pkg::PTR1_OFFSET, 32'h0);
    $display("test wrap and store done");
    mwr(11'h0e0, 8'h5c);
    apb(1'b1, mie_pkg::PTR0_OFFSET, 32'h100);
    exec(14'h3f20);
    chk("acc", 32'h5c, {24'h0, acc_out});
    rd("ptr0", mie_pkg::PTR0_OFFSET, 32'h100);
    exec(14'h3f9f);
    mrd(11'h11f, 8'h5c);
    $display("test relative done");
    exec(14'h003f);
    chk("bank", 32'hf, {28'h0, bank_select});
    exec(14'h31ff);
    chk("page", 32'h7f, {25'h0, program_counter_high_latch});
    exec(14'h0090);
    mrd(11'h790, 8'h5c);
    exec(14'h0080);
    mrd(11'h100, 8'h5c);
    exec(14'h3000);
    exec(14'h0091);
    exec(14'h3033);
    exec(14'h0811);
    chk("acc", 32'h0, {24'h0, acc_out});
    chk("zero", 32'h1, {31'h0, zero_out});
    exec(14'h0890);
    chk("zero", 32'h0, {31'h0, zero_out});
    mrd(11'h790, 8'h5c);
    $display("test bank page file copy done");
    rd("unmapped", 12'h024, 32'h0);
    apb(1'b1, mie_pkg::CTRL_OFFSET, 32'h0);
    exec(14'h3012);
    chk("ready", 32'h0, {31'h0, instr_ready});
    chk("acc", 32'h0, {24'h0, acc_out});
    apb(1'b1, mie_pkg::CTRL_OFFSET, 32'h1);
    $display("test refusals done");
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    $display("Error watchdog expected done seen hang");
    end_sim;
  end
endmodule

`default_nettype wire
